// [rtl/usart_mode_irq.sv]
// Behaviour
// - Filter enabled: 2-of-3 majority at 1/16 bit
// - T=0 limited: count errors, NACK until limit
// - Unlimited: NACK every parity error unless suppressed
// - Suppress set: never send NACK
// - Variable sync takes frame type from writes
// - Oversample 16x at zero, 8x at one
// - Drive clock pin when drive bit set, unless external source selected
// - Nine-bit, else 5 to 8 bits
// - Outside SPI: bit order select LSB/MSB
// - SPI: clock idle level follows polarity
// - SPI: phase picks change and sample edges
// - Loop field: normal, echo, local, remote
// - Stop bits 1, 1.5, 2, reserved codes
// - Parity even, odd, space, mark, none, multidrop
// - Outside SPI: sync bit picks async/sync
// - Clock source: peripheral, divided, external pin
// - Four-bit operating mode decode
// - Set register ones set mask bits
// - Clear register ones clear mask bits
// - Mask gates sources; mask read-only
// - Line-code bit aliased at 20 and 24
// - Mode writes ignored while write-protected
`include "usart_cfg.svh"
`default_nettype none
module usart_mode_irq (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                rstn,
   // APB slave
   input  wire usart_pkg::apb_req_t apb,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr,
   // Engine events and status
   input  wire logic [31:0]         status_flags,
   input  wire logic                clear_repeat,
   input  wire logic                char_done,
   input  wire logic                parity_err,
   input  wire logic                thr_write,
   input  wire logic                thr_sync_cmd,
   input  wire logic                sample_tick,
   input  wire logic                ser_clk,
   input  wire logic                tx_out,
   // Configuration to the engines
   output usart_pkg::line_cfg_t     line_cfg,
   output logic                     frame_sync_cmd,
   output logic                     receiver_in,
   // Pins
   input  wire logic                rxd_pin,
   output logic                     txd_pin,
   output logic                     clk_pin_o,
   output logic                     clk_pin_oe,
   output logic                     card_nack,
   // Interrupt request
   output logic                     irq
);
   logic [31:0] mode_q;
   logic [31:0] mask_q;
   logic        wprot_q;
   logic        repeat_reached_q;
   logic        thr_sync_q;
   logic        rx_filt;
   logic        limit_hit;
   logic        setup;
   logic        wr;
   logic        is_spi;
   logic [31:0] status_view;
   logic [31:0] mask_view;
   logic [31:0] rd_d;
   logic        err_d;
   usart_pkg::line_cfg_t cfg_d;

   // Line-code bit lives at one place and shows at both
   function automatic logic [31:0] alias_fold(input logic [31:0] v);
      logic [31:0] r;
      r = v & `IRQ_VALID;
      r[`IRQ_LCODE] = v[`IRQ_LCODE] | v[`IRQ_LCODE_ALIAS];
      r[`IRQ_LCODE_ALIAS] = 1'b0;
      return r;
   endfunction : alias_fold

   assign setup = apb.psel && !apb.penable;
   assign wr    = apb.psel && apb.penable && pready && apb.pwrite;

   // Answer always comes at the first access edge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup;
         prdata  <= setup && !apb.pwrite ? rd_d : 32'h00000000;
         pslverr <= setup && err_d;
      end
   end

   assign status_view = {status_flags[31:11], status_flags[10] | repeat_reached_q,
                         status_flags[9:0]};
   assign mask_view = {mask_q[31:25], mask_q[`IRQ_LCODE], mask_q[23:0]};

   always_comb begin
      rd_d  = 32'h00000000;
      err_d = 1'b0;
      case (apb.paddr)
         `REG_MODE:     rd_d = mode_q;
         `REG_IRQ_SET:  rd_d = 32'h00000000;
         `REG_IRQ_CLR:  rd_d = 32'h00000000;
         `REG_IRQ_MASK: rd_d = mask_view;
         `REG_STATUS:   rd_d = status_view;
         `REG_WPROT:    rd_d = {31'h00000000, wprot_q};
         default:       err_d = 1'b1;
      endcase
   end

   // Mode register, frozen under write protection
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mode_q <= `MODE_RESET;
      end else if (wr && apb.paddr == `REG_MODE && !wprot_q) begin
         mode_q <= apb.pwdata & `MODE_WMASK;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wprot_q <= 1'b0;
      end else if (wr && apb.paddr == `REG_WPROT) begin
         wprot_q <= apb.pwdata[`WP_ENABLE_BIT];
      end
   end

   // Mask only moves through the set and clear registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mask_q <= 32'h00000000;
      end else if (wr && apb.paddr == `REG_IRQ_SET) begin
         mask_q <= mask_q | alias_fold(apb.pwdata);
      end else if (wr && apb.paddr == `REG_IRQ_CLR) begin
         mask_q <= mask_q & ~alias_fold(apb.pwdata);
      end
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         repeat_reached_q <= 1'b0;
      end else if (limit_hit) begin
         repeat_reached_q <= 1'b1;
      end else if (clear_repeat) begin
         repeat_reached_q <= 1'b0;
      end
   end

   // Line-code source sits at the alias position of the status word
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_view & mask_view & ~(32'h1 << `IRQ_LCODE));
      end
   end

   // Configuration decode
   always_comb begin
      cfg_d = '0;
      case (mode_q[`F_OPMODE_HI:`F_OPMODE_LO])
         `OPM_NORMAL:     cfg_d.op_mode = usart_pkg::OPM_NORMAL;
         `OPM_RS485:      cfg_d.op_mode = usart_pkg::OPM_RS485;
         `OPM_HANDSHAKE:  cfg_d.op_mode = usart_pkg::OPM_HANDSHAKE;
         `OPM_MODEM:      cfg_d.op_mode = usart_pkg::OPM_MODEM;
         `OPM_ISO_T0:     cfg_d.op_mode = usart_pkg::OPM_ISO_T0;
         `OPM_ISO_T1:     cfg_d.op_mode = usart_pkg::OPM_ISO_T1;
         `OPM_IRDA:       cfg_d.op_mode = usart_pkg::OPM_IRDA;
         `OPM_LIN_MASTER: cfg_d.op_mode = usart_pkg::OPM_LIN_MASTER;
         `OPM_LIN_SLAVE:  cfg_d.op_mode = usart_pkg::OPM_LIN_SLAVE;
         `OPM_SPI_MASTER: cfg_d.op_mode = usart_pkg::OPM_SPI_MASTER;
         `OPM_SPI_SLAVE:  cfg_d.op_mode = usart_pkg::OPM_SPI_SLAVE;
         default:         cfg_d.op_mode = usart_pkg::OPM_RESERVED;
      endcase
      cfg_d.char_bits = mode_q[`F_NINE_BIT] ? `CHAR_NINE
                        : `CHAR_BASE + {2'h0, mode_q[`F_CHAR_LENGTH_SELECT_HI:`F_CHAR_LENGTH_SELECT_LO]};
      cfg_d.msb_first = !is_spi && mode_q[`F_ORDER_POL];
      cfg_d.spi_idle_high = is_spi && mode_q[`F_ORDER_POL];
      cfg_d.spi_phase = is_spi && mode_q[`F_SYNC_PHA];
      cfg_d.sync_mode = !is_spi && mode_q[`F_SYNC_PHA];
      cfg_d.oversample = mode_q[`F_OVER] ? `OVS_FAST : `OVS_NORMAL;
      cfg_d.clk_source = mode_q[`F_CLKSRC_HI:`F_CLKSRC_LO];
      cfg_d.loop_mode = mode_q[`F_LOOP_HI:`F_LOOP_LO];
      case (mode_q[`F_PAR_HI:`F_PAR_LO])
         3'h0:    cfg_d.parity = usart_pkg::PAR_EVEN;
         3'h1:    cfg_d.parity = usart_pkg::PAR_ODD;
         3'h2:    cfg_d.parity = usart_pkg::PAR_SPACE;
         3'h3:    cfg_d.parity = usart_pkg::PAR_MARK;
         3'h4:    cfg_d.parity = usart_pkg::PAR_NONE;
         3'h5:    cfg_d.parity = usart_pkg::PAR_NONE;
         default: cfg_d.parity = usart_pkg::PAR_MULTIDROP;
      endcase
      // Reserved stop codes fall back to one stop bit and raise a flag
      case (mode_q[`F_STOP_HI:`F_STOP_LO])
         2'h0: cfg_d.stop_halves = `STOP_ONE_HALVES;
         2'h1: cfg_d.stop_halves = cfg_d.sync_mode ? `STOP_ONE_HALVES : `STOP_ONEHALF;
         2'h2: cfg_d.stop_halves = `STOP_TWO_HALVES;
         default: cfg_d.stop_halves = `STOP_ONE_HALVES;
      endcase
      cfg_d.cfg_reserved = (mode_q[`F_STOP_HI:`F_STOP_LO] == 2'h3)
                           || (mode_q[`F_STOP_HI:`F_STOP_LO] == 2'h1 && cfg_d.sync_mode)
                           || cfg_d.clk_source == `CLKSRC_RSVD
                           || cfg_d.op_mode == usart_pkg::OPM_RESERVED;
   end

   assign is_spi = mode_q[`F_OPMODE_HI:`F_OPMODE_LO] == `OPM_SPI_MASTER
                   || mode_q[`F_OPMODE_HI:`F_OPMODE_LO] == `OPM_SPI_SLAVE;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         line_cfg <= '0;
      end else begin
         line_cfg <= cfg_d;
      end
   end

   // Frame delimiter type
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         thr_sync_q <= 1'b0;
      end else if (thr_write) begin
         thr_sync_q <= thr_sync_cmd;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         frame_sync_cmd <= 1'b0;
      end else begin
         frame_sync_cmd <= mode_q[`F_VAR_SYNC] ? thr_sync_q : mode_q[`F_SYNC_PHA];
      end
   end

   // Line routing; a local loopback keeps the pin idle high
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         txd_pin     <= 1'b1;
         receiver_in <= 1'b1;
      end else begin
         case (mode_q[`F_LOOP_HI:`F_LOOP_LO])
            `LOOP_ECHO: begin
               txd_pin     <= rx_filt;
               receiver_in <= rx_filt;
            end
            `LOOP_LOCAL: begin
               txd_pin     <= 1'b1;
               receiver_in <= tx_out;
            end
            `LOOP_REMOTE: begin
               txd_pin     <= rxd_pin;
               receiver_in <= 1'b1;
            end
            default: begin
               txd_pin     <= tx_out;
               receiver_in <= rx_filt;
            end
         endcase
      end
   end

   // Generator clock rests low, so the polarity sets the idle level
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         clk_pin_o  <= 1'b0;
         clk_pin_oe <= 1'b0;
      end else begin
         clk_pin_o  <= ser_clk ^ (is_spi && mode_q[`F_ORDER_POL]);
         clk_pin_oe <= mode_q[`F_CLK_DRIVE]
                       && mode_q[`F_CLKSRC_HI:`F_CLKSRC_LO] != `CLKSRC_EXT;
      end
   end

   rx_majority_filter u_filter (
      .clk         (clk),
      .rstn        (rstn),
      .enable      (mode_q[`F_FILTER]),
      .sample_tick (sample_tick),
      .rx_in       (rxd_pin),
      .rx_out      (rx_filt)
   );

   card_nack_ctrl u_nack (
      .clk               (clk),
      .rstn              (rstn),
      .iso_mode          (mode_q[`F_OPMODE_HI:`F_OPMODE_LO] == `OPM_ISO_T0
                          || mode_q[`F_OPMODE_HI:`F_OPMODE_LO] == `OPM_ISO_T1),
      .t0_mode           (mode_q[`F_OPMODE_HI:`F_OPMODE_LO] == `OPM_ISO_T0),
      .limit_repeat_nack (mode_q[`F_LIMIT_NACK]),
      .suppress_nack     (mode_q[`F_SUPPRESS_NACK]),
      .repeat_limit      (mode_q[`F_LIMIT_HI:`F_LIMIT_LO]),
      .char_done         (char_done),
      .parity_err        (parity_err),
      .nack_drive        (card_nack),
      .limit_hit         (limit_hit)
   );

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   property p_mask_set;
      wr && apb.paddr == `REG_IRQ_SET
      |=> (mask_q & alias_fold($past(apb.pwdata))) == alias_fold($past(apb.pwdata));
   endproperty
   a_mask_set: assert property (p_mask_set) else $error("set left a mask bit clear");

   property p_mask_keep;
      wr && apb.paddr == `REG_IRQ_SET |=> (mask_q & $past(mask_q)) == $past(mask_q);
   endproperty
   a_mask_keep: assert property (p_mask_keep) else $error("set cleared a mask bit");

   property p_mask_clr;
      wr && apb.paddr == `REG_IRQ_CLR
      |=> (mask_q & alias_fold($past(apb.pwdata))) == 32'h00000000;
   endproperty
   a_mask_clr: assert property (p_mask_clr) else $error("clear left a mask bit set");

   property p_mask_ro;
      wr && apb.paddr == `REG_IRQ_MASK |=> mask_q == $past(mask_q);
   endproperty
   a_mask_ro: assert property (p_mask_ro) else $error("mask changed by direct write");

   property p_alias;
      setup && apb.paddr == `REG_IRQ_MASK && !apb.pwrite |=> prdata[20] == prdata[24];
   endproperty
   a_alias: assert property (p_alias) else $error("line-code alias mismatch");

   property p_irq;
      ##1 irq == |($past(status_view) & $past(mask_view) & ~(32'h1 << `IRQ_LCODE));
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not tied to flags and mask");

   property p_wprot;
      wprot_q && wr && apb.paddr == `REG_MODE |=> $stable(mode_q);
   endproperty
   a_wprot: assert property (p_wprot) else $error("protected mode register changed");

   property p_clk_pin;
      mode_q[`F_CLKSRC_HI:`F_CLKSRC_LO] == `CLKSRC_EXT |=> !clk_pin_oe;
   endproperty
   a_clk_pin: assert property (p_clk_pin) else $error("clock pin driven on external");

   property p_char;
      mode_q[`F_NINE_BIT] |=> line_cfg.char_bits == 4'h9;
   endproperty
   a_char: assert property (p_char) else $error("nine-bit length not applied");

   property p_over;
      mode_q[`F_OVER] ##1 mode_q[`F_OVER] |-> line_cfg.oversample == 5'h08;
   endproperty
   a_over: assert property (p_over) else $error("8x oversampling not applied");

   property p_suppress;
      mode_q[`F_SUPPRESS_NACK] ##1 mode_q[`F_SUPPRESS_NACK] |-> !card_nack;
   endproperty
   a_suppress: assert property (p_suppress) else $error("NACK sent while suppressed");

   c_set_then_irq: cover property (wr && apb.paddr == `REG_IRQ_SET ##[1:4] irq);
   c_limit_hit: cover property (limit_hit ##1 repeat_reached_q);
   c_wprot_write: cover property (wprot_q && wr && apb.paddr == `REG_MODE);
endmodule : usart_mode_irq
`default_nettype wire

// [rtl/usart_cfg.svh]
`ifndef USART_CFG_SVH
`define USART_CFG_SVH

// Register byte addresses
`define REG_MODE          8'h04
`define REG_IRQ_SET       8'h08
`define REG_IRQ_CLR       8'h0C
`define REG_IRQ_MASK      8'h10
`define REG_STATUS        8'h14
`define REG_WPROT         8'hE4

// Mode register fields
`define MODE_WMASK        32'hF77FFFFF
`define MODE_RESET        32'h00000000
`define F_FILTER          28
`define F_LIMIT_HI        26
`define F_LIMIT_LO        24
`define F_VAR_SYNC        22
`define F_LIMIT_NACK      21
`define F_SUPPRESS_NACK   20
`define F_OVER            19
`define F_CLK_DRIVE       18
`define F_NINE_BIT        17
`define F_ORDER_POL       16
`define F_LOOP_HI         15
`define F_LOOP_LO         14
`define F_STOP_HI         13
`define F_STOP_LO         12
`define F_PAR_HI          11
`define F_PAR_LO          9
`define F_SYNC_PHA        8
`define F_CHAR_LENGTH_SELECT_HI         7
`define F_CHAR_LENGTH_SELECT_LO         6
`define F_CLKSRC_HI       5
`define F_CLKSRC_LO       4
`define F_OPMODE_HI       3
`define F_OPMODE_LO       0

// Interrupt mask fields and write-protect enable bit
`define IRQ_VALID         32'h3F1FF7E7
`define IRQ_LCODE         20
`define IRQ_LCODE_ALIAS   24
`define IRQ_REPEAT        10
`define WP_ENABLE_BIT     0

// Encodings
`define OPM_NORMAL        4'h0
`define OPM_RS485         4'h1
`define OPM_HANDSHAKE     4'h2
`define OPM_MODEM         4'h3
`define OPM_ISO_T0        4'h4
`define OPM_ISO_T1        4'h6
`define OPM_IRDA          4'h8
`define OPM_LIN_MASTER    4'hA
`define OPM_LIN_SLAVE     4'hB
`define OPM_SPI_MASTER    4'hE
`define OPM_SPI_SLAVE     4'hF
`define LOOP_NORMAL       2'h0
`define LOOP_ECHO         2'h1
`define LOOP_LOCAL        2'h2
`define LOOP_REMOTE       2'h3
`define CLKSRC_EXT        2'h3
`define CLKSRC_RSVD       2'h2
`define CHAR_BASE         4'h5
`define CHAR_NINE         4'h9
`define OVS_NORMAL        5'h10
`define OVS_FAST          5'h08
`define STOP_ONE_HALVES   3'h2
`define STOP_ONEHALF      3'h3
`define STOP_TWO_HALVES   3'h4

`endif

// [rtl/usart_pkg.sv]
`default_nettype none
package usart_pkg;

   typedef enum logic [3:0] {
      OPM_NORMAL, OPM_RS485, OPM_HANDSHAKE, OPM_MODEM, OPM_ISO_T0, OPM_ISO_T1,
      OPM_IRDA, OPM_LIN_MASTER, OPM_LIN_SLAVE, OPM_SPI_MASTER, OPM_SPI_SLAVE,
      OPM_RESERVED
   } op_mode_t;

   typedef enum logic [2:0] {
      PAR_EVEN, PAR_ODD, PAR_SPACE, PAR_MARK, PAR_NONE, PAR_MULTIDROP
   } parity_t;

   typedef struct packed {
      logic       paddr_dummy;
      logic       psel;
      logic       penable;
      logic       pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      op_mode_t   op_mode;
      logic [3:0] char_bits;
      logic       msb_first;
      parity_t    parity;
      logic [2:0] stop_halves;
      logic       sync_mode;
      logic       spi_phase;
      logic       spi_idle_high;
      logic [4:0] oversample;
      logic [1:0] clk_source;
      logic [1:0] loop_mode;
      logic       cfg_reserved;
   } line_cfg_t;

endpackage : usart_pkg
`default_nettype wire

// [rtl/rx_majority_filter.sv]
`default_nettype none
module rx_majority_filter (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rstn,
   // Control
   input  wire logic enable,
   input  wire logic sample_tick,
   // Line
   input  wire logic rx_in,
   output logic      rx_out
);
   logic [2:0] hist_q;

   // Idle line is high, so the history starts there
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hist_q <= 3'h7;
      end else if (sample_tick) begin
         hist_q <= {hist_q[1:0], rx_in};
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rx_out <= 1'b1;
      end else if (enable) begin
         rx_out <= (hist_q[0] & hist_q[1]) | (hist_q[1] & hist_q[2])
                   | (hist_q[0] & hist_q[2]);
      end else begin
         rx_out <= rx_in;
      end
   end
endmodule : rx_majority_filter
`default_nettype wire

// [rtl/card_nack_ctrl.sv]
`default_nettype none
module card_nack_ctrl (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rstn,
   // Settings
   input  wire logic       iso_mode,
   input  wire logic       t0_mode,
   input  wire logic       limit_repeat_nack,
   input  wire logic       suppress_nack,
   input  wire logic [2:0] repeat_limit,
   // Receiver events
   input  wire logic       char_done,
   input  wire logic       parity_err,
   // Results
   output logic            nack_drive,
   output logic            limit_hit
);
   logic [2:0] errs_q;
   logic       limited;

   assign limited = t0_mode && limit_repeat_nack;

   // A clean character ends the run of successive errors
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         errs_q <= 3'h0;
      end else if (char_done && !parity_err) begin
         errs_q <= 3'h0;
      end else if (char_done && limited && errs_q < repeat_limit) begin
         errs_q <= errs_q + 3'h1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         nack_drive <= 1'b0;
         limit_hit  <= 1'b0;
      end else begin
         nack_drive <= char_done && parity_err && iso_mode && !suppress_nack
                       && (!limited || errs_q < repeat_limit);
         limit_hit  <= char_done && parity_err && limited
                       && ({1'b0, errs_q} + 4'h1 >= {1'b0, repeat_limit});
      end
   end
endmodule : card_nack_ctrl
`default_nettype wire

// [testbench/card_peer.sv]
`default_nettype none
module card_peer (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rstn,
   // Card line
   input  wire logic       card_nack,
   input  wire logic       line_level,
   output logic            rxd_pin,
   // Observation
   output logic [7:0]      nack_count
);
   timeunit 1ns;
   timeprecision 1ns;
   // Bench picks the level; mark is high between characters
   assign rxd_pin = line_level;
   // Counts NACKs seen on the card line
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         nack_count <= 8'h00;
      end else if (card_nack) begin
         nack_count <= nack_count + 8'h01;
      end
   end
endmodule : card_peer
`default_nettype wire

// [testbench/test_usart_mode_irq.sv]
`include "usart_cfg.svh"
`default_nettype none
module test_usart_mode_irq;
   timeunit 1ns;
   timeprecision 1ns;
   logic                 clk, rstn, clear_repeat, char_done, parity_err;
   logic                 thr_write, thr_sync_cmd, pready, pslverr, irq;
   logic                 frame_sync_cmd, receiver_in, txd_pin, rxd_pin;
   logic                 clk_pin_o, clk_pin_oe, card_nack;
   logic [31:0]          prdata, status_flags, rd;
   logic [7:0]           nack_count;
   logic                 err;
   usart_pkg::apb_req_t  apb;
   usart_pkg::line_cfg_t line_cfg;
   int                   bad_count, compares;
   logic                 tx_out, ser_clk, sample_tick, line_level;
   logic [3:0]           spi_bits;
   logic [6:0]           frame_bits;
   // Pins {txd, receiver} for loop codes 3..0, with tx high and line low
   localparam logic [7:0] loop_exp = 8'h72;
   assign spi_bits   = {line_cfg.spi_idle_high, line_cfg.msb_first, line_cfg.spi_phase,
                        line_cfg.sync_mode};
   assign frame_bits = {line_cfg.parity, line_cfg.stop_halves, line_cfg.cfg_reserved};
   usart_mode_irq dut (.clk(clk), .rstn(rstn), .apb(apb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .status_flags(status_flags), .clear_repeat(clear_repeat),
      .char_done(char_done), .parity_err(parity_err), .thr_write(thr_write),
      .thr_sync_cmd(thr_sync_cmd), .sample_tick(sample_tick), .ser_clk(ser_clk), .tx_out(tx_out),
      .line_cfg(line_cfg), .frame_sync_cmd(frame_sync_cmd), .receiver_in(receiver_in),
      .rxd_pin(rxd_pin), .txd_pin(txd_pin), .clk_pin_o(clk_pin_o),
      .clk_pin_oe(clk_pin_oe), .card_nack(card_nack), .irq(irq));
   card_peer peer (.clk(clk), .rstn(rstn), .card_nack(card_nack), .rxd_pin(rxd_pin),
      .line_level(line_level), .nack_count(nack_count));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic check32(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check32
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      apb <= '{paddr_dummy: 1'b0, psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge clk);
      apb.penable <= 1'b1;
      @(posedge clk);
      // The wait ends on pready; only the watchdog ends a hung one
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rd = prdata;
      err = pslverr;
      apb.psel <= 1'b0;
      apb.penable <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : xfer
   task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h00000000);
      check32(what, exp, rd);
   endtask : rdchk
   task automatic chr(input logic perr);
      @(posedge clk);
      char_done <= 1'b1;
      parity_err <= perr;
      @(posedge clk);
      char_done <= 1'b0;
      parity_err <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : chr
   task automatic tick;
      @(posedge clk);
      sample_tick <= 1'b1;
      @(posedge clk);
      sample_tick <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : tick
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      #200us;
      bad_count++;
      tally_and_finish();
   end
   initial begin
      apb = '0;
      {rstn, clear_repeat, char_done, parity_err, thr_write, thr_sync_cmd} = 6'h00;
      {tx_out, line_level, ser_clk, sample_tick} = 4'hC;
      status_flags = 32'h00000000;
      bad_count = 0;
      compares = 0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      rdchk("mode reset", `REG_MODE, 32'h00000000);
      rdchk("mask reset", `REG_IRQ_MASK, 32'h00000000);
      xfer(1'b0, 8'h40, 32'h00000000);
      check32("unmapped err", 32'h00000001, {31'h0, err});
      xfer(1'b1, `REG_IRQ_SET, 32'h00000401);
      rdchk("mask set", `REG_IRQ_MASK, 32'h00000401);
      xfer(1'b1, `REG_IRQ_CLR, 32'h00000001);
      rdchk("mask clear", `REG_IRQ_MASK, 32'h00000400);
      xfer(1'b1, `REG_IRQ_SET, 32'h01000000);
      rdchk("mask alias", `REG_IRQ_MASK, 32'h01100400);
      xfer(1'b1, `REG_IRQ_MASK, 32'hFFFFFFFF);
      rdchk("mask ro", `REG_IRQ_MASK, 32'h01100400);
      status_flags <= 32'h00000400;
      repeat (3) @(posedge clk);
      check32("irq on", 32'h00000001, {31'h0, irq});
      xfer(1'b1, `REG_IRQ_CLR, 32'h00100400);
      rdchk("mask alias clr", `REG_IRQ_MASK, 32'h00000000);
      check32("irq masked", 32'h00000000, {31'h0, irq});
      status_flags <= 32'h00000000;
      for (int i = 0; i < 4; i++) begin
         xfer(1'b1, `REG_MODE, 32'(i) << 6);
         check32("char bits", 32'(5 + i), {28'h0, line_cfg.char_bits});
      end
      xfer(1'b1, `REG_MODE, 32'h000A0000);
      check32("nine bit", 32'h9, {28'h0, line_cfg.char_bits});
      check32("fast ovs", 32'h08, {27'h0, line_cfg.oversample});
      xfer(1'b1, `REG_MODE, 32'h00040000);
      check32("clk oe", 32'h1, {31'h0, clk_pin_oe});
      check32("slow ovs", 32'h10, {27'h0, line_cfg.oversample});
      xfer(1'b1, `REG_MODE, 32'h00040030);
      check32("clk oe ext", 32'h0, {31'h0, clk_pin_oe});
      xfer(1'b1, `REG_WPROT, 32'h00000001);
      xfer(1'b1, `REG_MODE, 32'h000000C0);
      rdchk("mode locked", `REG_MODE, 32'h00040030);
      xfer(1'b1, `REG_WPROT, 32'h00000000);
      xfer(1'b1, `REG_MODE, 32'h00400000);
      @(posedge clk);
      thr_write <= 1'b1;
      thr_sync_cmd <= 1'b1;
      @(posedge clk);
      thr_write <= 1'b0;
      repeat (3) @(posedge clk);
      check32("frame cmd", 32'h1, {31'h0, frame_sync_cmd});
      xfer(1'b1, `REG_MODE, 32'h02200004);
      repeat (3) chr(1'b1);
      check32("limited nacks", 32'h2, {24'h0, nack_count});
      rdchk("repeat flag", `REG_STATUS, 32'h00000400);
      @(posedge clk);
      clear_repeat <= 1'b1;
      @(posedge clk);
      clear_repeat <= 1'b0;
      rdchk("repeat cleared", `REG_STATUS, 32'h00000000);
      xfer(1'b1, `REG_MODE, 32'h00100004);
      chr(1'b1);
      check32("suppressed", 32'h2, {24'h0, nack_count});
      xfer(1'b1, `REG_MODE, 32'h00000004);
      chr(1'b1);
      chr(1'b0);
      chr(1'b1);
      check32("unlimited", 32'h4, {24'h0, nack_count});
      xfer(1'b1, `REG_MODE, 32'h0001010E);
      check32("spi cfg", 32'h0000000A, {28'h0, spi_bits});
      check32("spi mode", 32'(usart_pkg::OPM_SPI_MASTER), {28'h0, line_cfg.op_mode});
      check32("spi clk idle", 32'h1, {31'h0, clk_pin_o});
      xfer(1'b1, `REG_MODE, 32'h00011F00);
      check32("sync cfg", 32'h00000005, {28'h0, spi_bits});
      check32("frame cfg", 32'h00000055, {25'h0, frame_bits});
      check32("clk plain", 32'h0, {31'h0, clk_pin_o});
      xfer(1'b1, `REG_MODE, 32'h10000000);
      line_level <= 1'b0;
      tick();
      check32("filter one", 32'h1, {31'h0, receiver_in});
      tick();
      check32("filter two", 32'h0, {31'h0, receiver_in});
      for (int i = 0; i < 4; i++) begin
         xfer(1'b1, `REG_MODE, 32'(i) << 14);
         check32("loop pins", 32'(loop_exp[2*i +: 2]), {30'h0, txd_pin, receiver_in});
      end
      tally_and_finish();
   end
endmodule : test_usart_mode_irq
`default_nettype wire
